/* design/gpo_top.sv */
// Gesture pulse, wait and crosstalk offset configuration with the LED pulse sequencer.
`include "gpo_defines.svh"
// Summary of operation
// [RULE1] A three-bit wait code picks 0 to 39.2 ms idle between gesture cycles.
// [RULE2] Software should set the wait code before enabling the gesture engine.
// [RULE3] Integration lasts the programmed width; the LED stays on 1.33 us longer.
// [RULE4] Each directional offset is sign/magnitude: bit 7 negative, bits 6..0 magnitude.
// [RULE5] Each offset scales a correction applied to its own photodiode channel.
// [RULE6] Pulse width code 0..3 gives 4, 8, 16 or 32 us of integration time.
// [RULE7] Each gesture cycle emits the pulse count field plus one LED pulses.
// [RULE8] A sign-set zero-magnitude offset gives zero correction, like all zeros.
module gpo_top #(
    parameter int WAIT_STEP_CYC = `GPO_WAIT_STEP_NS / `GPO_CLK_PERIOD_NS,
    parameter int CORR_SHIFT = 0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [2:0] cycle_wait_code,
    input wire logic motion_engine_enable,
    input wire logic [31:0] pd_raw,
    input wire logic [3:0] pd_raw_valid,
    output logic [31:0] pd_corr,
    output logic [3:0] pd_corr_valid,
    output logic led_sink_pin,
    output logic integ_window
);
    localparam logic [3:0] WAIT_MULT [0:7] = '{`GPO_WAIT_MULT_0, `GPO_WAIT_MULT_1, `GPO_WAIT_MULT_2,
        `GPO_WAIT_MULT_3, `GPO_WAIT_MULT_4, `GPO_WAIT_MULT_5, `GPO_WAIT_MULT_6, `GPO_WAIT_MULT_7};
    localparam logic [15:0] BASE_CYC = 16'(`GPO_PLEN_BASE_CYC);
    localparam logic [15:0] MARGIN_CYC = 16'(`GPO_LED_MARGIN_CYC);
    localparam logic [23:0] GAP_CYC = 24'(`GPO_PULSE_GAP_CYC);

    logic rst_meta_ff;
    logic rst_sync_b;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_ff <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_b <= rst_meta_ff;
        end
    end

    gpo_pkg::gpo_byte_t north_crosstalk_offset_ff;
    gpo_pkg::gpo_byte_t south_crosstalk_offset_ff;
    gpo_pkg::gpo_byte_t west_crosstalk_offset_ff;
    gpo_pkg::gpo_byte_t east_crosstalk_offset_ff;
    gpo_pkg::gpo_byte_t led_pulse_shape_ff;
    logic [7:0] reg_rdata_ff;

    wire logic wr_north = reg_wr && (reg_addr == `GPO_ADDR_NORTH);
    wire logic wr_south = reg_wr && (reg_addr == `GPO_ADDR_SOUTH);
    wire logic wr_shape = reg_wr && (reg_addr == `GPO_ADDR_SHAPE);
    wire logic wr_west = reg_wr && (reg_addr == `GPO_ADDR_WEST);
    wire logic wr_east = reg_wr && (reg_addr == `GPO_ADDR_EAST);
    // Unmapped addresses read as zero.
    wire logic [7:0] nxt_rdata =
        (reg_addr == `GPO_ADDR_NORTH) ? north_crosstalk_offset_ff :
        (reg_addr == `GPO_ADDR_SOUTH) ? south_crosstalk_offset_ff :
        (reg_addr == `GPO_ADDR_SHAPE) ? led_pulse_shape_ff :
        (reg_addr == `GPO_ADDR_WEST) ? west_crosstalk_offset_ff :
        (reg_addr == `GPO_ADDR_EAST) ? east_crosstalk_offset_ff : 8'h00;

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            north_crosstalk_offset_ff <= `GPO_OFFSET_RST;
            south_crosstalk_offset_ff <= `GPO_OFFSET_RST;
            west_crosstalk_offset_ff <= `GPO_OFFSET_RST;
            east_crosstalk_offset_ff <= `GPO_OFFSET_RST;
            led_pulse_shape_ff <= `GPO_SHAPE_RST;
            reg_rdata_ff <= 8'h00;
        end else if (ce) begin
            if (wr_north) north_crosstalk_offset_ff <= reg_wdata;
            if (wr_south) south_crosstalk_offset_ff <= reg_wdata;
            if (wr_west) west_crosstalk_offset_ff <= reg_wdata;
            if (wr_east) east_crosstalk_offset_ff <= reg_wdata;
            if (wr_shape) led_pulse_shape_ff <= reg_wdata;
            reg_rdata_ff <= nxt_rdata;
        end
    end
    assign reg_rdata = reg_rdata_ff;

    // Channel order is north, south, west, east.
    wire gpo_pkg::gpo_byte_t offs [0:3] = '{north_crosstalk_offset_ff, south_crosstalk_offset_ff,
        west_crosstalk_offset_ff, east_crosstalk_offset_ff};
    gpo_chan_if chan [0:3] ();
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_chan
            assign chan[gi].offset_code = offs[gi]; // RULE5
            assign chan[gi].raw = pd_raw[gi*8 +: 8];
            assign chan[gi].raw_valid = pd_raw_valid[gi];
            assign pd_corr[gi*8 +: 8] = chan[gi].corr;
            assign pd_corr_valid[gi] = chan[gi].corr_valid;
            gpo_offset_scale #(.CORR_SHIFT(CORR_SHIFT)) u_scale (
                .clk(clk),
                .rst_sync_b(rst_sync_b),
                .ce(ce),
                .ch(chan[gi])
            );
        end
    endgenerate

    gpo_pkg::gpo_state_t state_ff;
    gpo_pkg::gpo_state_t nxt_state;
    logic [23:0] cnt_ff;
    logic [23:0] nxt_cnt;
    logic [5:0] pulse_idx_ff;
    logic [5:0] nxt_pulse_idx;
    logic [7:0] shape_lat_ff;
    logic [23:0] wait_tgt_ff;
    logic led_ff;
    logic integ_ff;

    // The shape is latched per gesture cycle so a write mid-cycle never tears a pulse train.
    wire logic cycle_start = (nxt_state == gpo_pkg::GPO_S_ON) &&
        (state_ff == gpo_pkg::GPO_S_IDLE || state_ff == gpo_pkg::GPO_S_WAIT);
    wire logic [7:0] shape_use = cycle_start ? led_pulse_shape_ff : shape_lat_ff;
    wire logic [15:0] width_cyc = 16'(BASE_CYC << shape_lat_ff[`GPO_PLEN_MSB:`GPO_PLEN_LSB]); // RULE6
    wire logic [15:0] on_cyc = width_cyc + MARGIN_CYC; // RULE3
    wire logic [15:0] nxt_width_cyc = 16'(BASE_CYC << shape_use[`GPO_PLEN_MSB:`GPO_PLEN_LSB]);
    wire logic [5:0] pcnt = shape_lat_ff[`GPO_PCNT_MSB:`GPO_PCNT_LSB];
    wire logic [23:0] wait_tgt = 24'(32'(WAIT_MULT[cycle_wait_code]) * WAIT_STEP_CYC); // RULE1
    // A zero wait still spends one cycle in the wait state.
    wire logic [23:0] wait_last = (wait_tgt_ff == 24'h0) ? 24'h0 : wait_tgt_ff - 24'h1;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff + 24'h1;
        nxt_pulse_idx = pulse_idx_ff;
        case (state_ff)
            gpo_pkg::GPO_S_IDLE: begin
                nxt_cnt = 24'h0;
                nxt_pulse_idx = 6'h00;
                if (motion_engine_enable) nxt_state = gpo_pkg::GPO_S_ON;
            end
            gpo_pkg::GPO_S_ON: begin
                if (cnt_ff == {8'h00, on_cyc} - 24'h1) begin
                    nxt_state = gpo_pkg::GPO_S_OFF;
                    nxt_cnt = 24'h0;
                end
            end
            gpo_pkg::GPO_S_OFF: begin
                if (cnt_ff == GAP_CYC - 24'h1) begin
                    nxt_cnt = 24'h0;
                    if (pulse_idx_ff == pcnt) begin // RULE7
                        nxt_state = gpo_pkg::GPO_S_WAIT;
                    end else begin
                        nxt_state = gpo_pkg::GPO_S_ON;
                        nxt_pulse_idx = pulse_idx_ff + 6'h01;
                    end
                end
            end
            gpo_pkg::GPO_S_WAIT: begin
                if (cnt_ff == wait_last) begin // RULE1
                    nxt_state = gpo_pkg::GPO_S_ON;
                    nxt_cnt = 24'h0;
                    nxt_pulse_idx = 6'h00;
                end
            end
            default: begin
                nxt_state = gpo_pkg::GPO_S_IDLE;
                nxt_cnt = 24'h0;
            end
        endcase
        if (!motion_engine_enable) begin
            nxt_state = gpo_pkg::GPO_S_IDLE;
            nxt_cnt = 24'h0;
        end
    end

    wire logic nxt_led = (nxt_state == gpo_pkg::GPO_S_ON);
    // Integration opens with the LED and closes the margin before it goes dark.
    wire logic nxt_integ = nxt_led && (nxt_cnt < {8'h00, nxt_width_cyc}); // RULE3

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state_ff <= gpo_pkg::GPO_S_IDLE;
            cnt_ff <= 24'h0;
            pulse_idx_ff <= 6'h00;
            shape_lat_ff <= `GPO_SHAPE_RST;
            wait_tgt_ff <= 24'h0;
            led_ff <= 1'b0;
            integ_ff <= 1'b0;
        end else if (ce) begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            pulse_idx_ff <= nxt_pulse_idx;
            shape_lat_ff <= shape_use;
            if (nxt_state == gpo_pkg::GPO_S_WAIT && state_ff != gpo_pkg::GPO_S_WAIT) wait_tgt_ff <= wait_tgt;
            led_ff <= nxt_led; // RULE6
            integ_ff <= nxt_integ;
        end
    end
    assign led_sink_pin = led_ff;
    assign integ_window = integ_ff;

    logic [15:0] led_len_ff;
    logic [15:0] integ_len_ff;
    logic [6:0] tally_ff;
    logic [23:0] wait_len_ff;
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            led_len_ff <= 16'h0;
            integ_len_ff <= 16'h0;
            tally_ff <= 7'h0;
            wait_len_ff <= 24'h0;
        end else if (ce) begin
            led_len_ff <= led_ff ? led_len_ff + 16'h1 : 16'h0;
            integ_len_ff <= integ_ff ? integ_len_ff + 16'h1 : 16'h0;
            if (state_ff == gpo_pkg::GPO_S_WAIT || state_ff == gpo_pkg::GPO_S_IDLE) tally_ff <= 7'h0;
            else if (state_ff == gpo_pkg::GPO_S_ON && nxt_state == gpo_pkg::GPO_S_OFF) tally_ff <= tally_ff + 7'h1;
            wait_len_ff <= (state_ff == gpo_pkg::GPO_S_WAIT) ? wait_len_ff + 24'h1 : 24'h0;
        end
    end

    sequence pulse_closes;
        ce && state_ff == gpo_pkg::GPO_S_ON && nxt_state == gpo_pkg::GPO_S_OFF;
    endsequence
    sequence train_closes;
        ce && state_ff == gpo_pkg::GPO_S_OFF && nxt_state == gpo_pkg::GPO_S_WAIT;
    endsequence

    led_width_a: assert property (@(posedge clk) disable iff (!rst_sync_b) // RULE6
        pulse_closes |=> integ_len_ff == 16'h0 && led_len_ff == 16'(BASE_CYC << $past(shape_lat_ff[7:6])) + MARGIN_CYC)
        else $error("LED on time does not match the pulse width code.");
    led_margin_a: assert property (@(posedge clk) disable iff (!rst_sync_b) // RULE3
        ce && integ_ff && !nxt_integ && nxt_led |=> led_ff && integ_len_ff == width_cyc ##0
        (led_ff || state_ff == gpo_pkg::GPO_S_IDLE) [*8])
        else $error("Integration window and LED margin are out of step.");
    pulse_tally_a: assert property (@(posedge clk) disable iff (!rst_sync_b) // RULE7
        train_closes |-> tally_ff == {1'b0, pcnt} + 7'h1)
        else $error("Pulse train length differs from count field plus one.");
    wait_len_a: assert property (@(posedge clk) disable iff (!rst_sync_b) // RULE1
        ce && state_ff == gpo_pkg::GPO_S_WAIT && nxt_state == gpo_pkg::GPO_S_ON |->
        wait_len_ff == wait_last && !led_ff ##1 led_ff)
        else $error("Wait between gesture cycles has the wrong length.");
endmodule

/* design/gpo_defines.svh */
// Register offsets, field positions, reset values and timing constants of the gesture pulse configuration.
`ifndef GPO_DEFINES_SVH
`define GPO_DEFINES_SVH

`define GPO_CLK_PERIOD_NS 10

`define GPO_ADDR_NORTH 8'hA4
`define GPO_ADDR_SOUTH 8'hA5
`define GPO_ADDR_SHAPE 8'hA6
`define GPO_ADDR_WEST 8'hA7
`define GPO_ADDR_EAST 8'hA9

`define GPO_OFFSET_RST 8'h00
`define GPO_SHAPE_RST 8'h00

`define GPO_SIGN_BIT 7
`define GPO_MAG_MSB 6
`define GPO_PLEN_MSB 7
`define GPO_PLEN_LSB 6
`define GPO_PCNT_MSB 5
`define GPO_PCNT_LSB 0

`define GPO_WAIT_STEP_NS 2800000
`define GPO_WAIT_MULT_0 4'h0
`define GPO_WAIT_MULT_1 4'h1
`define GPO_WAIT_MULT_2 4'h2
`define GPO_WAIT_MULT_3 4'h3
`define GPO_WAIT_MULT_4 4'h5
`define GPO_WAIT_MULT_5 4'h8
`define GPO_WAIT_MULT_6 4'hB
`define GPO_WAIT_MULT_7 4'hE

`define GPO_PLEN_BASE_NS 4000
`define GPO_PLEN_BASE_CYC ((`GPO_PLEN_BASE_NS + `GPO_CLK_PERIOD_NS - 1) / `GPO_CLK_PERIOD_NS)
`define GPO_LED_MARGIN_NS 1330
`define GPO_LED_MARGIN_CYC ((`GPO_LED_MARGIN_NS + `GPO_CLK_PERIOD_NS - 1) / `GPO_CLK_PERIOD_NS)
`define GPO_PULSE_GAP_NS 4000
`define GPO_PULSE_GAP_CYC ((`GPO_PULSE_GAP_NS + `GPO_CLK_PERIOD_NS - 1) / `GPO_CLK_PERIOD_NS)

`endif

/* design/gpo_pkg.sv */
// Types shared by the gesture pulse configuration modules.
package gpo_pkg;
    typedef logic [7:0] gpo_byte_t;
    typedef enum logic [1:0] {
        GPO_S_IDLE,
        GPO_S_ON,
        GPO_S_OFF,
        GPO_S_WAIT
    } gpo_state_t;
endpackage

/* design/gpo_chan_if.sv */
// Carrier between the top and one photodiode channel offset scaler.
interface gpo_chan_if;
    gpo_pkg::gpo_byte_t offset_code;
    gpo_pkg::gpo_byte_t raw;
    logic raw_valid;
    gpo_pkg::gpo_byte_t corr;
    logic corr_valid;
    modport host (output offset_code, output raw, output raw_valid, input corr, input corr_valid);
    modport scaler (input offset_code, input raw, input raw_valid, output corr, output corr_valid);
endinterface

/* design/gpo_offset_scale.sv */
// Applies one sign/magnitude crosstalk offset to one photodiode channel sample.
`include "gpo_defines.svh"
module gpo_offset_scale #(
    parameter int CORR_SHIFT = 0
) (
    input wire logic clk,
    input wire logic rst_sync_b,
    input wire logic ce,
    gpo_chan_if.scaler ch
);
    logic [7:0] corr_ff;
    logic corr_valid_ff;
    wire logic sgn = ch.offset_code[`GPO_SIGN_BIT];
    wire logic [6:0] mag = ch.offset_code[`GPO_MAG_MSB:0];
    // A negative zero code collapses to no correction at all.
    wire logic mag_zero = (mag == 7'h00); // RULE8
    wire logic [9:0] corr_amt = 10'({3'h0, mag} << CORR_SHIFT); // RULE5
    // Positive factor removes crosstalk, negative factor adds it back.
    wire logic [9:0] sum_add = {2'h0, ch.raw} + corr_amt; // RULE4
    wire logic [9:0] sum_sub = {2'h0, ch.raw} - corr_amt; // RULE4
    wire logic [7:0] res_add = (sum_add[9:8] != 2'h0) ? 8'hFF : sum_add[7:0];
    wire logic [7:0] res_sub = sum_sub[9] ? 8'h00 : (sum_sub[8] ? 8'hFF : sum_sub[7:0]);
    wire logic [7:0] nxt_corr = mag_zero ? ch.raw : (sgn ? res_add : res_sub); // RULE8

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            corr_ff <= 8'h00;
            corr_valid_ff <= 1'b0;
        end else if (ce) begin
            corr_valid_ff <= ch.raw_valid; // RULE5
            if (ch.raw_valid) begin
                corr_ff <= nxt_corr;
            end
        end
    end

    assign ch.corr = corr_ff;
    assign ch.corr_valid = corr_valid_ff;

    neg_raises_a: assert property (@(posedge clk) disable iff (!rst_sync_b) // RULE4
        ce && ch.raw_valid && sgn && !mag_zero |=> corr_ff >= $past(ch.raw))
        else $error("Negative offset lowered the channel value.");
    pos_lowers_a: assert property (@(posedge clk) disable iff (!rst_sync_b) // RULE4
        ce && ch.raw_valid && !sgn && !mag_zero |=> corr_ff < $past(ch.raw) || corr_ff == 8'h00)
        else $error("Positive offset did not lower the channel value.");
    zero_pass_a: assert property (@(posedge clk) disable iff (!rst_sync_b) // RULE8
        ce && ch.raw_valid && mag_zero |=> corr_ff == $past(ch.raw))
        else $error("Zero magnitude offset changed the channel value.");
    chan_valid_a: assert property (@(posedge clk) disable iff (!rst_sync_b) // RULE5
        ce && ch.raw_valid |=> corr_valid_ff)
        else $error("Corrected sample did not follow its raw sample.");
endmodule

/* bench/gesture_pulse_offset_config_test.sv */
// Self-checking testbench for the gesture pulse, wait and crosstalk offset configuration block.
`include "gpo_defines.svh"
`define GPOT_CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin fails++; \
    $display("FAIL %s expected %0h seen %0h", nm, exp, got); end end
module gesture_pulse_offset_config_test;
    timeunit 1ns;
    timeprecision 1ps;
    // The wait step is shortened so that all eight wait codes fit in one short run.
    localparam int STEP = 20;
    localparam int LIM = 5000;
    logic clk;
    logic rst_b;
    logic ce;
    logic [7:0] reg_addr;
    logic reg_wr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [2:0] cycle_wait_code;
    logic motion_engine_enable;
    logic [31:0] pd_raw;
    logic [3:0] pd_raw_valid;
    logic [31:0] pd_corr;
    logic [3:0] pd_corr_valid;
    logic led_sink_pin;
    logic integ_window;
    int fails;
    int compares;
    int seed;
    logic [7:0] addrs [5] = '{`GPO_ADDR_NORTH, `GPO_ADDR_SOUTH, `GPO_ADDR_SHAPE, `GPO_ADDR_WEST, `GPO_ADDR_EAST};
    logic [7:0] shadow [5];
    int lane_reg [4] = '{0, 1, 3, 4};
    logic [7:0] corner [6] = '{8'h00, 8'h80, 8'h7F, 8'hFF, 8'h05, 8'h85};
    logic [7:0] raw_corner [4] = '{8'h00, 8'hFF, 8'h64, 8'h03};

    gpo_top #(.WAIT_STEP_CYC(STEP), .CORR_SHIFT(0)) DUT (.clk(clk), .rst_b(rst_b), .ce(ce),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .cycle_wait_code(cycle_wait_code), .motion_engine_enable(motion_engine_enable),
        .pd_raw(pd_raw), .pd_raw_valid(pd_raw_valid), .pd_corr(pd_corr), .pd_corr_valid(pd_corr_valid),
        .led_sink_pin(led_sink_pin), .integ_window(integ_window));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [7:0] exp_corr(input logic [7:0] raw, input logic [7:0] off);
        int v;
        v = off[7] ? int'(raw) + int'(off[6:0]) : int'(raw) - int'(off[6:0]);
        if (v > 255) v = 255;
        if (v < 0) v = 0;
        return v[7:0];
    endfunction

    function automatic int wait_cyc(input logic [2:0] m);
        int mult [8] = '{0, 1, 2, 3, 5, 8, 11, 14};
        return (mult[m] * STEP < 1) ? 1 : mult[m] * STEP;
    endfunction

    task automatic give_verdict();
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Every drive happens one nanosecond after the rising edge, clear of the sampling edge.
    task automatic step();
        @(posedge clk);
        #1;
    endtask

    // The strobe drops for a cycle between writes so no signal is driven twice in one time step.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        step();
        reg_wr = 1'b0;
        step();
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        reg_addr = a;
        step();
        `GPOT_CHK("reg_rdata", e, reg_rdata)
    endtask

    task automatic chan(input logic [31:0] raw, input logic [3:0] mask);
        pd_raw = raw;
        pd_raw_valid = mask;
        step();
        `GPOT_CHK("pd_corr_valid", mask, pd_corr_valid)
        for (int l = 0; l < 4; l++) begin
            if (mask[l]) `GPOT_CHK("pd_corr", exp_corr(raw[8*l+:8], shadow[lane_reg[l]]), pd_corr[8*l+:8])
        end
        pd_raw_valid = 4'h0;
        step();
    endtask

    task automatic run_len(input logic lvl, output int n, output int ni);
        n = 0;
        ni = 0;
        while (led_sink_pin === lvl && n < LIM) begin
            ni += (integ_window === 1'b1) ? 1 : 0;
            n++;
            step();
        end
        if (n >= LIM) begin
            `GPOT_CHK("led_run_bound", 1'b0, 1'b1)
            give_verdict();
        end
    endtask

    initial begin
        int k;
        int n;
        int ni;
        int c;
        logic [7:0] v;
        logic [31:0] raw;
        seed = 65946;
        fails = 0;
        compares = 0;
        rst_b = 1'b0;
        ce = 1'b1;
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        cycle_wait_code = 3'h0;
        motion_engine_enable = 1'b0;
        pd_raw = 32'h0;
        pd_raw_valid = 4'h0;
        repeat (20) @(posedge clk);
        #1;
        rst_b = 1'b1;
        repeat (3) step();
        for (int i = 0; i < 5; i++) begin
            shadow[i] = (i == 2) ? `GPO_SHAPE_RST : `GPO_OFFSET_RST;
            rd_chk(addrs[i], shadow[i]);
        end
        repeat (20) begin
            k = int'(unsigned'($random(seed)) % 5);
            v = 8'($random(seed));
            wr_reg(addrs[k], v);
            shadow[k] = v;
            rd_chk(addrs[k], v);
        end
        // An unmapped address in the middle of the map must neither store nor disturb anything.
        wr_reg(8'hA8, 8'h5A);
        rd_chk(8'hA8, 8'h00);
        for (int i = 0; i < 5; i++) rd_chk(addrs[i], shadow[i]);
        for (int t = 0; t < 30; t++) begin
            for (int l = 0; l < 4; l++) begin
                v = (t < 6) ? corner[(t + l) % 6] : 8'($random(seed));
                raw[8*l+:8] = (t < 6) ? raw_corner[(t + l) % 4] : 8'($random(seed));
                wr_reg(addrs[lane_reg[l]], v);
                shadow[lane_reg[l]] = v;
            end
            chan(raw, (t < 6) ? 4'hF : 4'($random(seed)));
        end
        // A write offered while the clock enable is low must not land.
        ce = 1'b0;
        pd_raw_valid = 4'hF;
        reg_addr = `GPO_ADDR_NORTH;
        reg_wdata = ~shadow[0];
        reg_wr = 1'b1;
        step();
        `GPOT_CHK("pd_corr_valid_frozen", 4'h0, pd_corr_valid)
        ce = 1'b1;
        pd_raw_valid = 4'h0;
        reg_wr = 1'b0;
        step();
        rd_chk(`GPO_ADDR_NORTH, shadow[0]);
        for (int i = 0; i < 8; i++) begin
            // Short random trains keep the whole run inside its cycle budget after the 64-pulse corner.
            c = (i == 0) ? 63 : int'(unsigned'($random(seed)) % 2);
            wr_reg(`GPO_ADDR_SHAPE, {2'(i % 4), 6'(c)});
            // The wait code is settled before the engine is enabled.
            cycle_wait_code = 3'(i);
            step();
            motion_engine_enable = 1'b1;
            step();
            `GPOT_CHK("led_start", 1'b1, led_sink_pin)
            for (int p = 0; p <= c; p++) begin
                run_len(1'b1, n, ni);
                `GPOT_CHK("led_high", (`GPO_PLEN_BASE_CYC << (i % 4)) + `GPO_LED_MARGIN_CYC, n)
                `GPOT_CHK("integ_high", `GPO_PLEN_BASE_CYC << (i % 4), ni)
                run_len(1'b0, n, ni);
                `GPOT_CHK("integ_low", 0, ni)
                `GPOT_CHK("led_low", (p < c) ? `GPO_PULSE_GAP_CYC : `GPO_PULSE_GAP_CYC + wait_cyc(3'(i)), n)
            end
            `GPOT_CHK("led_retrain", 1'b1, led_sink_pin)
            motion_engine_enable = 1'b0;
            step();
            `GPOT_CHK("led_abort", 1'b0, led_sink_pin)
            `GPOT_CHK("integ_abort", 1'b0, integ_window)
        end
        give_verdict();
    end
endmodule
